// ### design/boot_serial_command_handler.sv
`timescale 1ns/10ps
module boot_serial_command_handler #(
   parameter int PW_BYTES = 12
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Receiver
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_error,
   input  wire logic        rate_ok,
   output wire logic        clocked_mode,
   // Transmitter
   output wire logic        tx_valid,
   output wire logic [7:0]  tx_data,
   input  wire logic        tx_ready,
   // Product information head (bytes 5-82)
   output wire logic [6:0]  info_index,
   input  wire logic [7:0]  info_head_byte,
   // Password store
   output wire logic [3:0]  pw_index,
   input  wire logic [7:0]  pw_stored,
   output wire logic        pw_error,
   // Flash engine
   output wire logic        erase_start,
   input  wire logic        erase_done,
   input  wire logic        erase_fail,
   output wire logic        security_flag,
   output wire logic        sum_start,
   input  wire logic        sum_done,
   input  wire logic [15:0] flash_sum,
   // RAM transfer hand-off
   output wire logic        ram_start,
   input  wire logic        ram_done,
   input  wire logic [31:0] ram_entry,
   output wire logic        run_user,
   output wire logic [31:0] run_addr
);
   initial begin
      if (PW_BYTES < 1 || PW_BYTES > 16) $error("password length unsupported");
   end

   // =====================================================
   // State
   boot_cmd_pkg::state_t state_q;
   boot_cmd_pkg::state_t state_d;
   logic        clocked_q;
   logic [7:0]  last_cmd_q;
   logic [7:0]  ack_q;
   logic [6:0]  byte_no_q;
   logic [4:0]  pw_cnt_q;
   logic        pw_bad_q;
   logic        rx_bad_q;
   logic        sec_q;
   logic        run_q;
   logic [31:0] run_addr_q;
   logic [15:0] sum_q;
   logic        sum_hi_q;

   // =====================================================
   // Decode
   wire        busy;
   wire        can_send    = !busy;
   wire        rx_err_eff  = rx_error && !clocked_q;
   wire        mode_ok     = rx_valid && rate_ok
                          && (rx_data == boot_cmd_pkg::MODE_ASYNC || rx_data == boot_cmd_pkg::MODE_CLOCKED);
   wire [7:0]  info_csum_neg;
   wire [7:0]  pw_sum_neg;
   wire        is_cmd_valid = (rx_data == boot_cmd_pkg::CMD_RAM_XFER)
                           || (rx_data == boot_cmd_pkg::CMD_FLASH_SUM)
                           || (rx_data == boot_cmd_pkg::CMD_PROD_INFO)
                           || (rx_data == boot_cmd_pkg::CMD_ERASE);
   wire [7:0]  nak_invalid = {rx_data[7:4], boot_cmd_pkg::NAK_INVALID};
   wire [7:0]  nak_rx_err  = {rx_data[7:4], boot_cmd_pkg::NAK_RX_ERROR};
   wire        ram_ok      = ram_entry >= boot_cmd_pkg::RAM_USER_BASE;
   wire        info_in_sum = byte_no_q <= boot_cmd_pkg::INFO_LAST_DATA;
   wire [7:0]  info_tail   = (byte_no_q == boot_cmd_pkg::INFO_BLK64_CNT) ? boot_cmd_pkg::BLK64_COUNT :
                             (byte_no_q == boot_cmd_pkg::INFO_SIZE128_2) ? boot_cmd_pkg::SIZE128_BYTE2 :
                             8'h00;
   wire [7:0]  info_byte   = (byte_no_q == boot_cmd_pkg::INFO_CSUM_BYTE) ? info_csum_neg :
                             (byte_no_q >= boot_cmd_pkg::INFO_BLK64_CNT) ? info_tail : info_head_byte;

   logic       load;
   logic [7:0] load_data;
   logic       sum_clear;
   logic       sum_add;
   logic       pw_clear;
   logic       pw_add;

   always_comb begin
      state_d   = state_q;
      load      = 1'b0;
      load_data = ack_q;
      sum_clear = 1'b0;
      sum_add   = 1'b0;
      pw_clear  = 1'b0;
      pw_add    = 1'b0;
      unique case (state_q)
         boot_cmd_pkg::ST_MODE: begin
            if (rx_valid && !rate_ok) begin
               state_d = boot_cmd_pkg::ST_DEAD;
            end else if (mode_ok) begin
               state_d = boot_cmd_pkg::ST_MODE_ACK;
            end
         end
         boot_cmd_pkg::ST_MODE_ACK: begin
            load = can_send;
            if (can_send) state_d = boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_CMD, boot_cmd_pkg::ST_CONFIRM: begin
            if (rx_valid) state_d = state_q == boot_cmd_pkg::ST_CMD ? boot_cmd_pkg::ST_CMD_ACK
                                                                   : boot_cmd_pkg::ST_CONF_ACK;
         end
         boot_cmd_pkg::ST_CMD_ACK: begin
            load = can_send;
            sum_clear = 1'b1;
            pw_clear  = 1'b1;
            if (can_send) begin
               if (rx_bad_q || ack_q[3:0] == boot_cmd_pkg::NAK_INVALID)
                  state_d = boot_cmd_pkg::ST_CMD;
               else if (last_cmd_q == boot_cmd_pkg::CMD_ERASE) state_d = boot_cmd_pkg::ST_CONFIRM;
               else if (last_cmd_q == boot_cmd_pkg::CMD_PROD_INFO) state_d = boot_cmd_pkg::ST_INFO;
               else if (last_cmd_q == boot_cmd_pkg::CMD_RAM_XFER) state_d = boot_cmd_pkg::ST_PASSWORD;
               else state_d = boot_cmd_pkg::ST_SUM;
            end
         end
         boot_cmd_pkg::ST_CONF_ACK: begin
            load = can_send;
            if (can_send) state_d = (ack_q == boot_cmd_pkg::ERASE_CONFIRM) ? boot_cmd_pkg::ST_ERASE
                                                                         : boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_ERASE: begin
            if (erase_done) state_d = boot_cmd_pkg::ST_ERASE_RES;
         end
         boot_cmd_pkg::ST_ERASE_RES: begin
            load = can_send;
            if (can_send) state_d = boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_INFO: begin
            load      = can_send;
            load_data = info_byte;
            sum_add   = can_send && info_in_sum;
            if (can_send && byte_no_q == boot_cmd_pkg::INFO_CSUM_BYTE) state_d = boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_PASSWORD: begin
            pw_add = rx_valid;
            if (rx_valid && pw_cnt_q == 5'(PW_BYTES)) state_d = boot_cmd_pkg::ST_PW_ACK;
         end
         boot_cmd_pkg::ST_PW_ACK: begin
            load = can_send;
            if (can_send) state_d = (ack_q == boot_cmd_pkg::CMD_RAM_XFER) ? boot_cmd_pkg::ST_DEAD
                                                                        : boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_SUM: begin
            if (sum_done) state_d = boot_cmd_pkg::ST_SUM_TX;
         end
         boot_cmd_pkg::ST_SUM_TX: begin
            load      = can_send;
            load_data = sum_hi_q ? sum_q[15:8] : sum_q[7:0];
            if (can_send && !sum_hi_q) state_d = boot_cmd_pkg::ST_CMD;
         end
         boot_cmd_pkg::ST_DEAD: begin
            state_d = boot_cmd_pkg::ST_DEAD;
         end
         default: state_d = boot_cmd_pkg::ST_DEAD;
      endcase
   end

   // =====================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= boot_cmd_pkg::ST_MODE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clocked_q  <= 1'b0;
         last_cmd_q <= 8'h00;
         ack_q      <= 8'h00;
         rx_bad_q   <= 1'b0;
      end else if (state_q == boot_cmd_pkg::ST_MODE && mode_ok) begin
         clocked_q <= rx_data == boot_cmd_pkg::MODE_CLOCKED;
         ack_q     <= rx_data;
      end else if ((state_q == boot_cmd_pkg::ST_CMD || state_q == boot_cmd_pkg::ST_CONFIRM) && rx_valid) begin
         rx_bad_q <= rx_err_eff;
         if (rx_err_eff) ack_q <= nak_rx_err;
         else if (state_q == boot_cmd_pkg::ST_CMD && is_cmd_valid) ack_q <= rx_data;
         else if (state_q == boot_cmd_pkg::ST_CONFIRM && rx_data == boot_cmd_pkg::ERASE_CONFIRM) ack_q <= rx_data;
         else ack_q <= nak_invalid;
         if (state_q == boot_cmd_pkg::ST_CMD) last_cmd_q <= rx_data;
      end else if (state_q == boot_cmd_pkg::ST_ERASE && erase_done) begin
         ack_q <= erase_fail ? boot_cmd_pkg::ERASE_FAIL : boot_cmd_pkg::ERASE_OK;
      end else if (state_q == boot_cmd_pkg::ST_PASSWORD && rx_valid && pw_cnt_q == 5'(PW_BYTES)) begin
         // Checksum byte completes the password sum to zero
         if (rx_bad_q || rx_err_eff) ack_q <= {last_cmd_q[7:4], boot_cmd_pkg::NAK_RX_ERROR};
         else if (pw_bad_q || rx_data != pw_sum_neg) ack_q <= {last_cmd_q[7:4], boot_cmd_pkg::NAK_INVALID};
         else ack_q <= boot_cmd_pkg::CMD_RAM_XFER;
      end else if (state_q == boot_cmd_pkg::ST_PASSWORD && rx_valid && rx_err_eff) begin
         rx_bad_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_no_q <= boot_cmd_pkg::INFO_FIRST_BYTE;
         pw_cnt_q  <= 5'h00;
         pw_bad_q  <= 1'b0;
         sum_hi_q  <= 1'b1;
         sum_q     <= 16'h0000;
      end else begin
         if (pw_clear) byte_no_q <= boot_cmd_pkg::INFO_FIRST_BYTE;
         else if (sum_add || (load && state_q == boot_cmd_pkg::ST_INFO)) byte_no_q <= 7'(byte_no_q + 1'b1);
         if (pw_clear) pw_cnt_q <= 5'h00;
         else if (pw_add) pw_cnt_q <= 5'(pw_cnt_q + 1'b1);
         if (pw_clear) pw_bad_q <= 1'b0;
         else if (pw_add && pw_cnt_q < 5'(PW_BYTES) && rx_data != pw_stored) pw_bad_q <= 1'b1;
         if (state_q == boot_cmd_pkg::ST_SUM && sum_done) sum_q <= flash_sum;
         if (state_q == boot_cmd_pkg::ST_SUM) sum_hi_q <= 1'b1;
         else if (state_q == boot_cmd_pkg::ST_SUM_TX && can_send) sum_hi_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_q <= 1'b0;
      end else if (state_q == boot_cmd_pkg::ST_ERASE && erase_done && !erase_fail) begin
         sec_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q      <= 1'b0;
         run_addr_q <= 32'h0000_0000;
      end else if (ram_start && ram_done && ram_ok) begin
         run_q      <= 1'b1;
         run_addr_q <= ram_entry;
      end
   end

   // =====================================================
   // Children
   byte_sender u_sender (
      .clk       (clk),
      .rst       (rst),
      .load      (load),
      .load_data (load_data),
      .busy      (busy),
      .tx_valid  (tx_valid),
      .tx_data   (tx_data),
      .tx_ready  (tx_ready)
   );

   sum_accumulator #(.WIDTH(8)) u_info_sum (
      .clk      (clk),
      .rst      (rst),
      .clear    (sum_clear),
      .add      (sum_add),
      .add_data (info_byte),
      .sum      (),
      .sum_neg  (info_csum_neg)
   );

   sum_accumulator #(.WIDTH(8)) u_pw_sum (
      .clk      (clk),
      .rst      (rst),
      .clear    (pw_clear),
      .add      (pw_add && pw_cnt_q < 5'(PW_BYTES)),
      .add_data (rx_data),
      .sum      (),
      .sum_neg  (pw_sum_neg)
   );

   // Only sums leave, never raw flash
   assign info_index    = byte_no_q;
   assign pw_index      = pw_cnt_q[3:0];
   assign pw_error      = pw_bad_q;
   assign clocked_mode  = clocked_q;
   assign erase_start   = state_q == boot_cmd_pkg::ST_CONF_ACK && can_send && ack_q == boot_cmd_pkg::ERASE_CONFIRM;
   assign sum_start     = state_q == boot_cmd_pkg::ST_SUM;
   assign ram_start     = state_q == boot_cmd_pkg::ST_DEAD && ack_q == boot_cmd_pkg::CMD_RAM_XFER && !run_q;
   assign security_flag = sec_q;
   assign run_user      = run_q;
   assign run_addr      = run_addr_q;
endmodule // boot_serial_command_handler

// ### design/boot_cmd_pkg.sv
package boot_cmd_pkg;

   // =====================================================
   // Link-type bytes
   localparam logic [7:0] MODE_ASYNC      = 8'h86;
   localparam logic [7:0] MODE_CLOCKED    = 8'h30;

   // =====================================================
   // Command codes
   localparam logic [7:0] CMD_RAM_XFER    = 8'h10;
   localparam logic [7:0] CMD_FLASH_SUM   = 8'h20;
   localparam logic [7:0] CMD_PROD_INFO   = 8'h30;
   localparam logic [7:0] CMD_ERASE       = 8'h40;
   localparam logic [7:0] ERASE_CONFIRM   = 8'h54;

   // =====================================================
   // Answer codes
   localparam logic [3:0] NAK_INVALID     = 4'h1;
   localparam logic [3:0] NAK_RX_ERROR    = 4'h8;
   localparam logic [7:0] ERASE_OK        = 8'h4F;
   localparam logic [7:0] ERASE_FAIL      = 8'h4C;

   // =====================================================
   // Product information first byte and tail, byte numbers as counted on the link
   localparam logic [6:0] INFO_FIRST_BYTE = 7'h05;
   localparam logic [6:0] INFO_BLK64_CNT  = 7'h53;
   localparam logic [6:0] INFO_SIZE128_2  = 7'h5A;
   localparam logic [6:0] INFO_LAST_DATA  = 7'h5C;
   localparam logic [6:0] INFO_CSUM_BYTE  = 7'h5D;
   localparam logic [7:0] BLK64_COUNT     = 8'h01;
   localparam logic [7:0] SIZE128_BYTE2   = 8'h01;

   // =====================================================
   // RAM window for downloaded code
   localparam logic [31:0] RAM_USER_BASE  = 32'h2000_0400;
   localparam logic [31:0] RAM_RSVD_LAST  = 32'h2000_03FF;

   // =====================================================
   // Handler states
   typedef enum logic [3:0] {
      ST_MODE      = 4'b0000,
      ST_MODE_ACK  = 4'b0001,
      ST_CMD       = 4'b0010,
      ST_CMD_ACK   = 4'b0011,
      ST_CONFIRM   = 4'b0100,
      ST_CONF_ACK  = 4'b0101,
      ST_ERASE     = 4'b0110,
      ST_ERASE_RES = 4'b0111,
      ST_INFO      = 4'b1000,
      ST_PASSWORD  = 4'b1001,
      ST_PW_ACK    = 4'b1010,
      ST_SUM       = 4'b1011,
      ST_SUM_TX    = 4'b1100,
      ST_DEAD      = 4'b1101
   } state_t;

endpackage

// ### design/byte_sender.sv
`timescale 1ns/10ps
// =====================================================
// Single-byte holding stage towards the serial transmitter
module byte_sender (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // From handler
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   output wire logic       busy,
   // To transmitter
   output wire logic       tx_valid,
   output wire logic [7:0] tx_data,
   input  wire logic       tx_ready
);
   logic       full_q;
   logic [7:0] data_q;

   assign busy     = full_q;
   assign tx_valid = full_q;
   assign tx_data  = data_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         full_q <= 1'b0;
         data_q <= 8'h00;
      end else if (load && !full_q) begin
         full_q <= 1'b1;
         data_q <= load_data;
      end else if (tx_ready) begin
         full_q <= 1'b0;
      end
   end
endmodule // byte_sender

// ### design/sum_accumulator.sv
`timescale 1ns/10ps
// =====================================================
// Carry-dropping byte adder, also gives two's complement
module sum_accumulator #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control
   input  wire logic             clear,
   input  wire logic             add,
   input  wire logic [WIDTH-1:0] add_data,
   // Result
   output wire logic [WIDTH-1:0] sum,
   output wire logic [WIDTH-1:0] sum_neg
);
   logic [WIDTH-1:0] sum_q;

   initial begin
      if (WIDTH < 8) $error("sum width below one byte");
   end

   assign sum     = sum_q;
   assign sum_neg = WIDTH'(~sum_q + 1'b1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sum_q <= '0;
      end else if (clear) begin
         sum_q <= '0;
      end else if (add) begin
         sum_q <= WIDTH'(sum_q + add_data);
      end
   end
endmodule // sum_accumulator

// ### verification/boot_serial_command_handler_props.sv
`timescale 1ns/10ps
// ==========================================
// Port-level checks of the boot command handler
module boot_handler_props #(
   parameter int PW_BYTES = 12
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Link
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_error,
   input wire logic        rate_ok,
   input wire logic        clocked_mode,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_ready,
   // Flash and RAM hand-off
   input wire logic        erase_done,
   input wire logic        erase_fail,
   input wire logic        security_flag,
   input wire logic        ram_start,
   input wire logic        ram_done,
   input wire logic [31:0] ram_entry,
   input wire logic        run_user,
   input wire logic [31:0] run_addr
);
   logic seen_q;
   wire  first_byte = rx_valid && !seen_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) seen_q <= 1'b0;
      else if (rx_valid) seen_q <= 1'b1;
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   sequence echo_s(logic [7:0] b);
      ##2 tx_valid && tx_data == b;
   endsequence

   property mode_echo_p;
      logic [7:0] b;
      (first_byte && rate_ok && (rx_data == boot_cmd_pkg::MODE_ASYNC || rx_data == boot_cmd_pkg::MODE_CLOCKED),
       b = rx_data) |-> echo_s(b);
   endproperty

   a_mode_echo: assert property (mode_echo_p)
      else $error("link-type byte not echoed");
   a_bad_rate_silent: assert property (first_byte && !rate_ok |=> !tx_valid [*8])
      else $error("byte sent after unusable rate");
   a_clocked_flag: assert property (first_byte && rate_ok |=>
      clocked_mode == ($past(rx_data) == boot_cmd_pkg::MODE_CLOCKED))
      else $error("clocked mode flag wrong");
   a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("output byte dropped or changed");
   a_erase_ok: assert property (erase_done && !erase_fail |-> echo_s(boot_cmd_pkg::ERASE_OK))
      else $error("erase success code missing");
   a_erase_fail: assert property (erase_done && erase_fail |-> echo_s(boot_cmd_pkg::ERASE_FAIL))
      else $error("erase failure code missing");
   a_secure_set: assert property (erase_done && !erase_fail |-> ##2 security_flag)
      else $error("security flag not set");
   a_no_rxerr_nak: assert property (rx_valid && rx_error && clocked_mode |->
      ##2 !(tx_valid && tx_data[3:0] == boot_cmd_pkg::NAK_RX_ERROR))
      else $error("error answer in clocked mode");
   a_run_entry: assert property (ram_start && ram_done && ram_entry >= boot_cmd_pkg::RAM_USER_BASE |=>
      run_user && run_addr == $past(ram_entry))
      else $error("downloaded code not started");
   a_low_entry: assert property (ram_done && ram_entry < boot_cmd_pkg::RAM_USER_BASE && !run_user |=> !run_user)
      else $error("start in reserved region");
endmodule // boot_handler_props

bind boot_serial_command_handler boot_handler_props #(.PW_BYTES(PW_BYTES)) u_props (
   .clk, .rst, .rx_valid, .rx_data, .rx_error, .rate_ok, .clocked_mode, .tx_valid, .tx_data, .tx_ready,
   .erase_done, .erase_fail, .security_flag, .ram_start, .ram_done, .ram_entry, .run_user, .run_addr);

// ### verification/boot_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host end of the boot link, byte level
module boot_host_model (
   // Clock
   input  wire logic       clk,
   // Towards handler
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic       rx_error,
   output var  logic       rate_ok,
   // From handler
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output wire logic       tx_ready
);
   logic [7:0] got[$];
   logic       stall = 1'b0;
   logic [1:0] cnt_q = 2'b00;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_error = 1'b0;
      rate_ok  = 1'b1;
   end

   // Slow consumer accepts one cycle in four
   assign tx_ready = !stall || (cnt_q == 2'b11);

   always @(posedge clk) begin
      cnt_q <= cnt_q + 2'b01;
      if (tx_valid && tx_ready) got.push_back(tx_data);
   end

   // whole bytes only, rate below byte level
   task automatic send(input logic [7:0] b, input logic err, input logic ok);
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_data  = b;
      rx_error = err;
      rate_ok  = ok;
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data  = ~b;
      rx_error = 1'b0;
   endtask
endmodule // boot_host_model

// ### verification/boot_serial_command_handler_test.sv
`timescale 1ns/10ps
module boot_serial_command_handler_test;
   localparam int PW_BYTES = 12;
   logic        clk, rst, rx_valid, rx_error, rate_ok, clocked_mode, tx_valid, tx_ready, pw_error;
   logic        erase_start, erase_done, erase_fail, security_flag, sum_start, sum_done;
   logic        ram_start, ram_done, run_user;
   logic [7:0]  rx_data, tx_data, info_head_byte, pw_stored;
   logic [6:0]  info_index;
   logic [3:0]  pw_index;
   logic [15:0] flash_sum;
   logic [31:0] ram_entry, run_addr;
   int          err_count, comparisons;

   assign info_head_byte = {1'b1, info_index} ^ 8'h3C;
   assign pw_stored      = 8'hA0 + {4'h0, pw_index};

   boot_serial_command_handler #(.PW_BYTES(PW_BYTES)) dut (.clk, .rst, .rx_valid, .rx_data, .rx_error,
      .rate_ok, .clocked_mode, .tx_valid, .tx_data, .tx_ready, .info_index, .info_head_byte, .pw_index,
      .pw_stored, .pw_error, .erase_start, .erase_done, .erase_fail, .security_flag, .sum_start, .sum_done,
      .flash_sum, .ram_start, .ram_done, .ram_entry, .run_user, .run_addr);
   boot_host_model host (.clk, .rx_valid, .rx_data, .rx_error, .rate_ok, .tx_valid, .tx_data, .tx_ready);

   // ==========================================
   // Shared helpers
   task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait, as a host gives up on a silent device
   task automatic expect_tx(input logic [7:0] exp, input string what);
      int n;
      n = 0;
      while (host.got.size() == 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(what, {24'h0, exp}, host.got.size() != 0 ? {24'h0, host.got.pop_front()} : 32'hxxxx_xxxx);
   endtask

   function automatic logic pick(input int sel);
      return sel == 0 ? erase_start : sel == 1 ? sum_start : ram_start;
   endfunction

   task automatic wait_for(input int sel, input string what);
      int n;
      n = 0;
      while (pick(sel) !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(what, 1, pick(sel));
   endtask

   task do_reset;
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      host.got.delete();
   endtask

   // ==========================================
   // Scenarios
   task t_bad_rate;
      do_reset;
      host.send(boot_cmd_pkg::MODE_ASYNC, 1'b0, 1'b0);
      host.send(boot_cmd_pkg::MODE_ASYNC, 1'b0, 1'b1);
      repeat (20) @(posedge clk);
      check("bytes after bad rate", 0, host.got.size());
      $display("test bad rate done");
   endtask

   task t_async_erase;
      int f;
      do_reset;
      host.send(boot_cmd_pkg::MODE_ASYNC, 1'b0, 1'b1);
      expect_tx(boot_cmd_pkg::MODE_ASYNC, "mode echo");
      check("clocked flag", 0, clocked_mode);
      host.send(boot_cmd_pkg::CMD_ERASE, 1'b1, 1'b1);
      expect_tx(8'h48, "receive error answer");
      host.send(8'h51, 1'b0, 1'b1);
      expect_tx(8'h51, "invalid code answer");
      host.send(boot_cmd_pkg::CMD_ERASE, 1'b0, 1'b1);
      expect_tx(boot_cmd_pkg::CMD_ERASE, "erase ack");
      host.send(8'h55, 1'b0, 1'b1);
      expect_tx(8'h51, "confirm nack");
      for (f = 0; f < 2; f++) begin
         host.send(boot_cmd_pkg::CMD_ERASE, 1'b0, 1'b1);
         expect_tx(boot_cmd_pkg::CMD_ERASE, "erase ack");
         host.send(boot_cmd_pkg::ERASE_CONFIRM, 1'b0, 1'b1);
         wait_for(0, "erase start");
         expect_tx(boot_cmd_pkg::ERASE_CONFIRM, "confirm ack");
         @(posedge clk);
         #1;
         erase_fail = f[0];
         erase_done = 1'b1;
         @(posedge clk);
         #1;
         erase_done = 1'b0;
         expect_tx(f != 0 ? boot_cmd_pkg::ERASE_FAIL : boot_cmd_pkg::ERASE_OK, "erase result");
         check("security flag", 1, security_flag);
      end
      $display("test async erase done");
   endtask

   task t_clocked;
      int i;
      logic [7:0] e, cs;
      do_reset;
      host.stall = 1'b1;
      host.send(boot_cmd_pkg::MODE_CLOCKED, 1'b0, 1'b1);
      expect_tx(boot_cmd_pkg::MODE_CLOCKED, "mode echo");
      check("clocked flag", 1, clocked_mode);
      host.send(boot_cmd_pkg::CMD_FLASH_SUM, 1'b1, 1'b1);
      expect_tx(boot_cmd_pkg::CMD_FLASH_SUM, "sum ack");
      wait_for(1, "sum start");
      @(posedge clk);
      #1;
      flash_sum = 16'hBEEF;
      sum_done  = 1'b1;
      @(posedge clk);
      #1;
      sum_done = 1'b0;
      expect_tx(8'hBE, "sum high");
      expect_tx(8'hEF, "sum low");
      host.send(boot_cmd_pkg::CMD_PROD_INFO, 1'b0, 1'b1);
      expect_tx(boot_cmd_pkg::CMD_PROD_INFO, "info ack");
      cs = 8'h00;
      for (i = 5; i <= 93; i++) begin
         e = (i <= 82) ? ({1'b1, 7'(i)} ^ 8'h3C) : (i == 83 || i == 90) ? 8'h01 : (i == 93) ? -cs : 8'h00;
         cs = cs + e;
         expect_tx(e, "info byte");
      end
      $display("test clocked sum and info done");
   endtask

   task t_ram;
      int t, k;
      logic [7:0] b, s;
      for (t = 0; t < 2; t++) begin
         host.send(boot_cmd_pkg::CMD_RAM_XFER, 1'b0, 1'b1);
         expect_tx(boot_cmd_pkg::CMD_RAM_XFER, "ram ack");
         s = 8'h00;
         for (k = 0; k < PW_BYTES; k++) begin
            b = 8'hA0 + 8'(k) + ((t == 0 && k == 0) ? 8'h01 : 8'h00);
            s = s + b;
            host.send(b, 1'b0, 1'b1);
         end
         host.send(-s, 1'b0, 1'b1);
         expect_tx(t == 0 ? 8'h11 : 8'h10, "password answer");
         if (t == 0) check("password error", 1, pw_error);
      end
      wait_for(2, "ram start");
      #1;
      ram_entry = 32'h2000_03FF;
      ram_done  = 1'b1;
      @(posedge clk);
      #1;
      ram_done = 1'b0;
      repeat (4) @(posedge clk);
      check("run in reserved area", 0, run_user);
      #1;
      ram_entry = 32'h2000_0400;
      ram_done  = 1'b1;
      @(posedge clk);
      #1;
      ram_done = 1'b0;
      repeat (2) @(posedge clk);
      check("run flag", 1, run_user);
      check("run address", 32'h2000_0400, run_addr);
      $display("test ram transfer done");
   endtask

   task finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #200000;
      err_count++;
      finish_test;
   end

   initial begin
      rst = 1'b1;
      erase_done = 1'b0;
      erase_fail = 1'b0;
      sum_done = 1'b0;
      flash_sum = 16'h0000;
      ram_done = 1'b0;
      ram_entry = 32'h0000_0000;
      err_count = 0;
      comparisons = 0;
      t_bad_rate;
      t_async_erase;
      t_clocked;
      t_ram;
      finish_test;
   end
endmodule // boot_serial_command_handler_test
